// [hdl/srac_pkg.sv]
/*
 Constants for the host-side secure region controller: flash command
 addresses and data, region bounds and bus timing counts.
 Assumes a 100 MHz clock and a word-wide asynchronous flash bus.
*/
package srac_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // Unlock and command sequence addresses and data.
   localparam logic [10:0] ADDR_UNLOCK1 = 11'h555;
   localparam logic [10:0] ADDR_UNLOCK2 = 11'h2AA;
   localparam logic [10:0] ADDR_EXIT4 = 11'h000;
   localparam logic [15:0] DATA_UNLOCK1 = 16'h00AA;
   localparam logic [15:0] DATA_UNLOCK2 = 16'h0055;
   localparam logic [15:0] DATA_ENTRY = 16'h0088;
   localparam logic [15:0] DATA_EXIT3 = 16'h0090;
   localparam logic [15:0] DATA_EXIT4 = 16'h0000;
   localparam logic [15:0] DATA_PROG_SETUP = 16'h00A0;
   // Secure region layout in words.
   localparam int REGION_WORDS = 128;
   localparam logic [6:0] SERIAL_LAST = 7'h07;
   // Identification-mode lock indicator location and bit.
   localparam logic [10:0] ADDR_LOCK_IND = 11'h003;
   localparam int LOCK_IND_BIT = 7;
   // Bus timing: strobes held longer than the glitch filter width.
   localparam int GLITCH_NS = 5;
   localparam int STROBE_NS = 40;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_MIN_NS = 500;
   localparam int RESET_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
   localparam logic [7:0] RESET_CNT = 8'(RESET_CYC);
   // Host command codes.
   typedef enum logic [2:0] {
      SRAC_CMD_READ = 3'b000,
      SRAC_CMD_ENTER = 3'b001,
      SRAC_CMD_EXIT = 3'b010,
      SRAC_CMD_PROG = 3'b011,
      SRAC_CMD_RESET = 3'b100
   } srac_cmd_t;
endpackage : srac_pkg

// [hdl/srac_cyc_if.sv]
/*
 Interface carrying one bus cycle request from the sequencer to the
 cycle engine, and its completion back.
 Assumes both ends share the single system clock.
*/
`timescale 1ns/10ps
interface srac_cyc_if;
   logic start;
   logic write;
   logic [21:0] addr;
   logic [15:0] wdata;
   logic done;
   logic [15:0] rdata;
   modport seq (output start, output write, output addr, output wdata,
      input done, input rdata);
   modport eng (input start, input write, input addr, input wdata,
      output done, output rdata);
endinterface : srac_cyc_if

// [hdl/srac_cycle.sv]
/*
 Cycle engine: runs one asynchronous read or write cycle on the flash
 pins with strobes held well past the device glitch filter.
 Assumes the flash data bus is shared and turned round by output enable.
*/
`timescale 1ns/10ps
module srac_cycle
   import srac_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Request side.
   srac_cyc_if.eng cyc,
   // Flash strobes and data pins.
   output logic ce_n_q,
   output logic oe_n_q,
   output logic we_n_q,
   output logic [21:0] addr_q,
   output logic [15:0] dq_out_q,
   output logic dq_oe_q,
   input wire logic [15:0] dq_in
);
   logic [7:0] cnt_q;
   logic busy_q;
   logic done_q;
   logic [15:0] rdata_q;

   assign cyc.done = done_q;
   assign cyc.rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Strobe timing. Strobes stay low for STROBE_CNT + 1 cycles, far above the
   // glitch width, so every write is seen as a real cycle.
   always_ff @(posedge clock) begin
      done_q <= 1'b0;
      if (reset) begin
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
         ce_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         we_n_q <= 1'b1;
         addr_q <= '0;
         dq_out_q <= 16'h0000;
         dq_oe_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else if (!busy_q && cyc.start) begin
         busy_q <= 1'b1;
         cnt_q <= STROBE_CNT;
         ce_n_q <= 1'b0;
         oe_n_q <= cyc.write; // [R15]
         we_n_q <= !cyc.write; // [R15]
         addr_q <= cyc.addr;
         dq_out_q <= cyc.wdata;
         dq_oe_q <= cyc.write; // Never drive while the flash may drive.
      end else if (busy_q) begin
         if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
         end else begin
            // Write data is latched by the flash on the rising strobe.
            busy_q <= 1'b0;
            done_q <= 1'b1;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            dq_oe_q <= 1'b0;
            rdata_q <= dq_in;
         end
      end
   end
endmodule : srac_cycle

// [hdl/srac_host.sv]
/*
 Host controller for a flash secure region: issues entry, exit, word
 program and read sequences, and a timed hardware reset pulse.
 Assumes the flash pins attach directly and the supply is above lockout.
*/
`timescale 1ns/10ps
// How it works
// [R1] Secure region is 128 words; reads beyond it give undefined data.
// [R2] Lock indicator is bit 7 of identification address 03h.
// [R3] After power-up or reset the device reads the normal array.
// [R4] In secure mode lowest sector addresses map onto the secure region.
// [R5] Secure region refused while a program or erase runs.
// [R6] No accelerated or unlock-bypass programming in secure mode.
// [R7] Entry: 555h/AAh, 2AAh/55h, 555h/88h.
// [R8] Exit: 555h/AAh, 2AAh/55h, 555h/90h, 000h/00h.
// [R9] Program: two unlocks, 555h/A0h, then target address and data.
// [R10] Secure mode persists until exit or power loss.
// [R11] Factory-locked part stays protected, indicator fixed at 1.
// [R12] Words 0-7 hold serial number; 8-7Fh are customer space.
// [R13] Customer part programs and locks once; locked indicator reads 0.
// [R14] Below lockout voltage all writes are ignored.
// [R15] Strobe pulses under 5 ns do not start a write.
// [R16] Power-up write inhibit; state machine starts in read mode.
// [R17] Deselected device tristates outputs; running operations finish.
// [R18] Stable address enters auto sleep; output data stays valid.
// [R19] Reset low for the minimum width aborts and returns to read.
// [R20] Output enable high tristates data, except ready/busy.
// [R21] Host restarts an operation interrupted by reset. This host does not restart it; the caller must reissue it.
// [R22] Mismatched command cycle abandons the sequence.
module srac_host
   import srac_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Command port.
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic [21:0] cmd_addr,
   input wire logic [15:0] cmd_wdata,
   output logic cmd_ready_q,
   output logic rsp_valid_q,
   output logic [15:0] rsp_rdata_q,
   output logic rsp_error_q,
   output logic secure_mode_q,
   // Flash pins.
   output logic ce_n_q,
   output logic oe_n_q,
   output logic we_n_q,
   output logic reset_n_q,
   output logic [21:0] addr_q,
   output logic [15:0] dq_out_q,
   output logic dq_oe_q,
   input wire logic [15:0] dq_in,
   input wire logic ready_busy_n
);
   typedef enum logic [2:0] {
      SRAC_IDLE = 3'b000,
      SRAC_RUN = 3'b001,
      SRAC_WAIT = 3'b010,
      SRAC_RST = 3'b011,
      SRAC_DONE = 3'b100
   } srac_state_t;

   srac_state_t state_q;
   srac_cmd_t op_q;
   logic [2:0] step_q;
   logic [21:0] taddr_q;
   logic [15:0] tdata_q;
   logic [7:0] rcnt_q;
   logic start_q;
   logic rb_q;
   logic busy_seen_q;
   logic [21:0] seq_addr;
   logic [15:0] seq_data;
   logic seq_write;
   logic seq_last;

   srac_cyc_if cyc ();

   srac_cycle u_cycle (
      .clock(clock),
      .reset(reset),
      .cyc(cyc.eng),
      .ce_n_q(ce_n_q),
      .oe_n_q(oe_n_q),
      .we_n_q(we_n_q),
      .addr_q(addr_q),
      .dq_out_q(dq_out_q),
      .dq_oe_q(dq_oe_q),
      .dq_in(dq_in)
   );

   // Widen an 11-bit command address to the full word address.
   function automatic logic [21:0] cmd_a(input logic [10:0] a);
      return {11'h000, a};
   endfunction : cmd_a

   ////////////////////////////////////////////////////////////////////////
   // Sequence table: address and data for each step of each operation.
   always_comb begin
      seq_addr = cmd_a(ADDR_UNLOCK1);
      seq_data = DATA_UNLOCK1;
      seq_write = 1'b1;
      seq_last = 1'b0;
      case (step_q)
         3'd0: begin
            seq_addr = (op_q == SRAC_CMD_READ) ? taddr_q
               : cmd_a(ADDR_UNLOCK1);
            seq_write = (op_q != SRAC_CMD_READ);
            seq_last = (op_q == SRAC_CMD_READ);
         end
         3'd1: begin
            seq_addr = cmd_a(ADDR_UNLOCK2);
            seq_data = DATA_UNLOCK2;
         end
         3'd2: begin
            case (op_q)
               SRAC_CMD_ENTER: seq_data = DATA_ENTRY; // [R7]
               SRAC_CMD_EXIT: seq_data = DATA_EXIT3; // [R8]
               default: seq_data = DATA_PROG_SETUP; // [R9]
            endcase
            seq_last = (op_q == SRAC_CMD_ENTER);
         end
         3'd3: begin
            // Program target, or the exit's 000h/00h cycle; no bypass or accelerated form is used. [R6]
            seq_addr = (op_q == SRAC_CMD_EXIT) ? cmd_a(ADDR_EXIT4)
               : taddr_q; // [R8] [R9]
            seq_data = (op_q == SRAC_CMD_EXIT) ? DATA_EXIT4 : tdata_q;
            seq_last = 1'b1;
         end
         default: begin
            seq_last = 1'b1;
         end
      endcase
   end

   assign cyc.start = start_q;
   assign cyc.write = seq_write;
   assign cyc.addr = seq_addr;
   assign cyc.wdata = seq_data;

   ////////////////////////////////////////////////////////////////////////
   // Ready/busy is sampled so a program is waited out before the next
   // command; secure region access during a program would be refused.
   always_ff @(posedge clock) begin
      if (reset) begin
         rb_q <= 1'b1;
      end else begin
         rb_q <= ready_busy_n; // [R5]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequencer.
   always_ff @(posedge clock) begin
      start_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      if (reset) begin
         state_q <= SRAC_RST;
         op_q <= SRAC_CMD_READ;
         step_q <= 3'd0;
         taddr_q <= '0;
         tdata_q <= 16'h0000;
         rcnt_q <= RESET_CNT;
         reset_n_q <= 1'b0; // Power-up: hold the flash in reset. [R16]
         cmd_ready_q <= 1'b0;
         rsp_rdata_q <= 16'h0000;
         rsp_error_q <= 1'b0;
         secure_mode_q <= 1'b0; // [R3]
         busy_seen_q <= 1'b0;
      end else begin
         case (state_q)
            SRAC_IDLE: begin
               if (cmd_valid) begin
                  cmd_ready_q <= 1'b0;
                  op_q <= srac_cmd_t'(cmd_code);
                  taddr_q <= cmd_addr;
                  tdata_q <= cmd_wdata;
                  step_q <= 3'd0;
                  rsp_error_q <= 1'b0;
                  if (srac_cmd_t'(cmd_code) == SRAC_CMD_RESET) begin
                     state_q <= SRAC_RST;
                     rcnt_q <= RESET_CNT;
                     reset_n_q <= 1'b0; // [R19]
                  end else if (srac_cmd_t'(cmd_code) == SRAC_CMD_PROG
                     && secure_mode_q
                     && cmd_addr[21:7] != 15'h0000) begin
                     // Beyond the 128-word region: refused here. [R1]
                     rsp_error_q <= 1'b1;
                     state_q <= SRAC_DONE;
                  end else begin
                     start_q <= 1'b1;
                     state_q <= SRAC_RUN;
                  end
               end
            end
            SRAC_RUN: begin
               if (cyc.done) begin
                  if (seq_last) begin
                     rsp_rdata_q <= cyc.rdata;
                     if (op_q == SRAC_CMD_ENTER) begin
                        secure_mode_q <= 1'b1; // [R7] [R4]
                     end
                     if (op_q == SRAC_CMD_EXIT) begin
                        secure_mode_q <= 1'b0; // [R8] [R10]
                     end
                     busy_seen_q <= 1'b0;
                     rcnt_q <= RESET_CNT; // Fresh wait budget per program.
                     state_q <= (op_q == SRAC_CMD_PROG) ? SRAC_WAIT
                        : SRAC_DONE;
                  end else begin
                     step_q <= step_q + 3'd1;
                     start_q <= 1'b1;
                  end
               end
            end
            SRAC_WAIT: begin
               // Program runs; a locked region never goes busy, so the wait ends on the rcnt_q timer. [R13]
               if (!rb_q) begin
                  busy_seen_q <= 1'b1;
               end
               if (rb_q && (busy_seen_q || rcnt_q == 8'h00)) begin
                  state_q <= SRAC_DONE;
               end
               if (rcnt_q != 8'h00) begin
                  rcnt_q <= rcnt_q - 8'h01;
               end
            end
            SRAC_RST: begin
               // Pulse long enough to abort the device; it returns to
               // array read, so secure mode is gone and the caller
               // must reissue any cut-off operation. [R19] [R3] [R21]
               secure_mode_q <= 1'b0;
               if (rcnt_q != 8'h00) begin
                  rcnt_q <= rcnt_q - 8'h01;
               end else begin
                  reset_n_q <= 1'b1;
                  rcnt_q <= RESET_CNT;
                  state_q <= SRAC_DONE;
               end
            end
            SRAC_DONE: begin
               rsp_valid_q <= 1'b1;
               cmd_ready_q <= 1'b1;
               state_q <= SRAC_IDLE;
            end
            default: begin
               state_q <= SRAC_IDLE;
            end
         endcase
      end
   end
endmodule : srac_host

// [tb/srac_host_properties.sv]
/*
 Checker for the secure region host: pin and handshake timing.
 Assumes it is bound to srac_host and sees only its ports.
*/
`timescale 1ns/10ps
module srac_host_properties
   import srac_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Command handshake.
   input wire logic rsp_valid_q,
   input wire logic rsp_error_q,
   input wire logic secure_mode_q,
   // Flash pins.
   input wire logic ce_n_q,
   input wire logic oe_n_q,
   input wire logic we_n_q,
   input wire logic reset_n_q,
   input wire logic dq_oe_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic [7:0] low_cnt_q;
   ////////////////////////////////////////////////////////////////////////
   // Length of the flash reset pulse; it saturates so long holds stay legal.
   always_ff @(posedge clock) begin
      if (reset) low_cnt_q <= 8'h00;
      else if (reset_n_q) low_cnt_q <= 8'h00;
      else if (low_cnt_q != 8'hff) low_cnt_q <= low_cnt_q + 8'h01;
   end
   ////////////////////////////////////////////////////////////////////////
   a_strobe_excl: assert property (!(!we_n_q && !oe_n_q))
      else $error("write and output enable low together");
   a_write_selected: assert property (!we_n_q |-> !ce_n_q)
      else $error("write strobe without chip select");
   a_we_width: assert property ($fell(we_n_q) |-> !we_n_q [*4])
      else $error("write strobe too short");
   a_write_drives_dq: assert property (!we_n_q |-> dq_oe_q)
      else $error("write strobe without data driven");
   a_read_frees_dq: assert property (!oe_n_q |-> !dq_oe_q)
      else $error("host drives data during a read");
   a_reset_width: assert property (
      $rose(reset_n_q) |-> low_cnt_q >= RESET_CNT)
      else $error("flash reset pulse too short");
   a_quiet_in_reset: assert property (!reset_n_q |-> we_n_q && oe_n_q)
      else $error("strobe during flash reset");
   a_error_with_rsp: assert property (
      $rose(rsp_error_q) |-> ##1 rsp_valid_q)
      else $error("error flag without response");
   a_reset_leaves: assert property (
      $fell(reset_n_q) |-> ##1 !secure_mode_q)
      else $error("secure mode kept over flash reset");
   c_enter: cover property ($rose(secure_mode_q));
   c_error: cover property (rsp_error_q && rsp_valid_q);
   c_flash_reset: cover property ($rose(reset_n_q));
endmodule : srac_host_properties
bind srac_host srac_host_properties chk (.*);

// [tb/srac_flash_model.sv]
/*
 Behavioural flash with a secure region, decoding writes when the first
 of chip select and write strobe rises. Assumes word addresses below 256.
*/
`timescale 1ns/10ps
module srac_flash_model #(
   parameter int SECTOR_WORDS = 256,
   parameter int BUSY_NS = 300
) (
   // Flash pins.
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic reset_n,
   input wire logic [21:0] addr,
   input wire logic [15:0] dq,
   output logic [15:0] dq_in,
   output logic ready_busy_n
);
   logic [15:0] sec [128];
   logic [15:0] arr [256];
   logic [1:0] step;
   logic secure, exit_p, prog_p, locked, supply_ok;
   logic [15:0] rd;
   initial begin
      for (int i = 0; i < 256; i++) arr[i] = 16'(i);
      for (int i = 0; i < 128; i++) sec[i] = 16'h5e00 + 16'(i);
      {step, secure, exit_p, prog_p} = '0;
      ready_busy_n = 1'b1;
      // Customer part ships unlocked; the bench may lock it.
      locked = 1'b0;
      supply_ok = 1'b1; // Supply above lockout.
   end
   ////////////////////////////////////////////////////////////////////////
   // Lowest sector maps onto the region only in secure mode; no fast path.
   // Output only follows the address, so held data stays valid.
   assign rd = (secure && addr < SECTOR_WORDS && ready_busy_n) ?
      sec[addr[6:0]] : arr[addr[7:0]];
   // A released bus shows the inverse, never the last value.
   assign dq_in = (!ce_n && !oe_n && reset_n) ? rd : ~rd;
   // Reset pulse aborts any command sequence and returns to array read.
   always @(negedge reset_n) {step, secure, exit_p, prog_p} = '0;
   // Command decoder; any unexpected cycle drops the sequence. A write
   // ends on the first of the two strobes to rise, so chip select going
   // high in the same step as the write strobe cannot hide the cycle.
   always @(posedge (we_n | ce_n)) begin
      if (reset_n && supply_ok) begin
         if (prog_p) begin
            if (secure && addr < 128) begin
               // A locked region changes no bit and never goes busy.
               if (!locked) sec[addr[6:0]] = dq;
            end else arr[addr[7:0]] = dq;
            if (!(secure && addr < 128 && locked)) begin
               ready_busy_n = 1'b0;
               ready_busy_n <= #(BUSY_NS) 1'b1;
            end
            prog_p = 1'b0;
         end else if (exit_p) begin
            if (addr == 22'h0 && dq == 16'h0000) secure = 1'b0;
            exit_p = 1'b0;
         end else if (step == 2'd0 && addr == 22'h555 && dq == 16'h00aa)
            step = 2'd1;
         else if (step == 2'd1 && addr == 22'h2aa && dq == 16'h0055)
            step = 2'd2;
         else begin
            if (step == 2'd2 && addr == 22'h555) begin
               secure = secure | (dq == 16'h0088);
               exit_p = (dq == 16'h0090);
               prog_p = (dq == 16'h00a0);
            end
            step = 2'd0;
         end
      end
   end
endmodule : srac_flash_model

// [tb/srac_host_bench.sv]
/*
 Testbench for srac_host against the behavioural flash model.
 Assumes a 100 MHz clock and the command codes of the package.
*/
`timescale 1ns/10ps
module srac_host_bench
   import srac_pkg::*;
;
   logic clock, reset, cmd_valid, ce_n, oe_n, we_n, rst_n, dq_oe, rdy;
   logic cmd_ready, rsp_valid, rsp_error, secure;
   logic [2:0] cmd_code;
   logic [21:0] cmd_addr, addr;
   logic [15:0] cmd_wdata, rsp_rdata, dq_out, dq_in;
   int fails = 0;
   int compares = 0;
   srac_host dut (.clock(clock), .reset(reset), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_ready_q(cmd_ready), .rsp_valid_q(rsp_valid),
      .rsp_rdata_q(rsp_rdata), .rsp_error_q(rsp_error),
      .secure_mode_q(secure), .ce_n_q(ce_n), .oe_n_q(oe_n), .we_n_q(we_n),
      .reset_n_q(rst_n), .addr_q(addr), .dq_out_q(dq_out),
      .dq_oe_q(dq_oe), .dq_in(dq_in), .ready_busy_n(rdy));
   srac_flash_model flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .reset_n(rst_n), .addr(addr), .dq(dq_out), .dq_in(dq_in),
      .ready_busy_n(rdy));
   ////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One command, with bounded waits for ready and for the response.
   task cmd(input srac_cmd_t c, input logic [21:0] a, input logic [15:0] d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 3000) begin
         @(negedge clock);
         n++;
      end
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge clock);
      cmd_valid <= 1'b0;
      do begin
         @(negedge clock);
         n++;
      end while (rsp_valid !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         fails++;
         end_sim();
      end
   endtask : cmd
   ////////////////////////////////////////////////////////////////////////
   // Enter, program, read the serial number, refuse out of range, exit.
   task s_secure;
      chk("mode after reset", 16'(secure), 16'h0000);
      cmd(SRAC_CMD_ENTER, 22'h0, 16'h0);
      chk("mode after entry", {15'h0, flash.secure}, 16'h0001);
      chk("host mode after entry", 16'(secure), 16'h0001);
      cmd(SRAC_CMD_PROG, 22'h10, 16'h1234);
      chk("program status", 16'(rsp_error), 16'h0000);
      cmd(SRAC_CMD_READ, 22'h10, 16'h0);
      chk("secure word", rsp_rdata, 16'h1234);
      cmd(SRAC_CMD_READ, 22'h3, 16'h0);
      chk("serial word", rsp_rdata, 16'h5e03);
      cmd(SRAC_CMD_PROG, 22'h80, 16'h4321);
      chk("range refusal", 16'(rsp_error), 16'h0001);
      cmd(SRAC_CMD_EXIT, 22'h0, 16'h0);
      chk("mode after exit", {15'h0, flash.secure}, 16'h0000);
      chk("host mode after exit", 16'(secure), 16'h0000);
      cmd(SRAC_CMD_READ, 22'h10, 16'h0);
      chk("array word", rsp_rdata, 16'h0010);
   endtask : s_secure
   // A flash reset pulse drops secure mode on both sides.
   task s_flash_reset;
      cmd(SRAC_CMD_ENTER, 22'h0, 16'h0);
      cmd(SRAC_CMD_RESET, 22'h0, 16'h0);
      chk("host mode after pulse", 16'(secure), 16'h0000);
      chk("flash mode after pulse", {15'h0, flash.secure}, 16'h0000);
   endtask : s_flash_reset
   // A locked region takes a program with no change and no busy time,
   // so the host ends its wait on its own timer.
   task s_locked;
      flash.locked = 1'b1;
      cmd(SRAC_CMD_ENTER, 22'h0, 16'h0);
      cmd(SRAC_CMD_PROG, 22'h11, 16'hbeef);
      chk("locked program status", 16'(rsp_error), 16'h0000);
      cmd(SRAC_CMD_READ, 22'h11, 16'h0);
      chk("locked word", rsp_rdata, 16'h5e11);
      cmd(SRAC_CMD_EXIT, 22'h0, 16'h0);
      flash.locked = 1'b0;
   endtask : s_locked
   // Writes below the lockout supply are lost; exit brings both views back.
   task s_lockout;
      flash.supply_ok = 1'b0;
      cmd(SRAC_CMD_ENTER, 22'h0, 16'h0);
      chk("mode under lockout", {15'h0, flash.secure}, 16'h0000);
      flash.supply_ok = 1'b1;
      cmd(SRAC_CMD_EXIT, 22'h0, 16'h0);
      chk("host mode resynced", 16'(secure), 16'h0000);
   endtask : s_lockout
   // A system reset between commands drops secure mode and pulses the flash.
   task s_sys_reset;
      cmd(SRAC_CMD_ENTER, 22'h0, 16'h0);
      chk("host mode before reset", 16'(secure), 16'h0001);
      @(posedge clock);
      reset <= 1'b1;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      chk("host mode in reset", 16'(secure), 16'h0000);
      chk("ready in reset", 16'(cmd_ready), 16'h0000);
      cmd(SRAC_CMD_READ, 22'h10, 16'h0);
      chk("array after reset", rsp_rdata, 16'h0010);
   endtask : s_sys_reset
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd_code = 3'b000;
      cmd_addr = 22'h0;
      cmd_wdata = 16'h0000;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      s_secure();
      s_flash_reset();
      s_locked();
      s_lockout();
      s_sys_reset();
      end_sim();
   end
endmodule : srac_host_bench
